// ---- sim/rrr_exec_props.sv ----
module rrr_exec_props (
  input wire logic                     clk,
  input wire logic                     srst,
  input wire logic                     instr_valid,
  input wire logic [15:0]              instr,
  input wire logic                     instr_in_slot,
  input wire logic                     ready,
  input wire logic [31:0]              gr_rdata,
  input wire logic [31:0]              status_word,
  input wire logic [31:0]              saved_status_word,
  input wire logic [1:0]               repeat_flags,
  input wire rrr_pkg::rrr_gr_wr_type   gr_wr,
  input wire rrr_pkg::rrr_word_wr_type sw_wr,
  input wire rrr_pkg::rrr_word_wr_type pc_wr,
  input wire rrr_pkg::rrr_exc_type     exc,
  input wire logic                     irq_hold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////
  // Decode of accepted issues
  logic [31:0] gr_prev_q;  // Operand seen at issue
  wire  take = instr_valid && ready;
  wire  t_reg = take && (instr & rrr_pkg::MSK_REG) == rrr_pkg::OPC_SET_REG;
  wire  t_imm = take && (instr & rrr_pkg::MSK_IMM) == rrr_pkg::OPC_SET_IMM;
  wire  t_ret = take && (instr == rrr_pkg::OPC_RTE || instr == rrr_pkg::OPC_RTS);
  // Operand one cycle back
  always_ff @(posedge clk) begin
    gr_prev_q <= gr_rdata;
  end
  sequence s_quiet_sw;
    !sw_wr.we ##1 !sw_wr.we;
  endsequence
  ////////////////////////////////////////////////////////////////////
  property p_rotate_left_op;
    take && (instr & rrr_pkg::MSK_REG) == rrr_pkg::OPC_ROTATE_LEFT_OP |=> gr_wr.we && gr_wr.t_we
      && gr_wr.t_val == gr_prev_q[31] && gr_wr.data == {gr_prev_q[30:0], gr_prev_q[31]};
  endproperty
  a_rotate_left_op: assert property (p_rotate_left_op) else $error("rotate left result wrong");
  property p_rotate_right_op;
    take && (instr & rrr_pkg::MSK_REG) == rrr_pkg::OPC_ROTATE_RIGHT_OP |=> gr_wr.we && gr_wr.t_we
      && gr_wr.t_val == gr_prev_q[0] && gr_wr.data == {gr_prev_q[0], gr_prev_q[31:1]};
  endproperty
  a_rotate_right_op: assert property (p_rotate_right_op) else $error("rotate right result wrong");
  property p_rte_sw;
    take && instr == rrr_pkg::OPC_RTE && !instr_in_slot && status_word[rrr_pkg::SW_MD_BIT]
      |=> !sw_wr.we [*3] ##1 (sw_wr.we && sw_wr.data == $past(saved_status_word, 4));
  endproperty
  a_rte_sw: assert property (p_rte_sw) else $error("status restore late or wrong");
  property p_rte_user;
    take && instr == rrr_pkg::OPC_RTE && !instr_in_slot && !status_word[rrr_pkg::SW_MD_BIT]
      |=> exc.valid && exc.cause == rrr_pkg::CAUSE_ILL_INSTR && !sw_wr.we;
  endproperty
  a_rte_user: assert property (p_rte_user) else $error("user return not refused");
  property p_ret_slot;
    t_ret && instr_in_slot |=> exc.valid && exc.cause == rrr_pkg::CAUSE_ILL_SLOT;
  endproperty
  a_ret_slot: assert property (p_ret_slot) else $error("return in slot not flagged");
  property p_hold;
    t_ret && !instr_in_slot && (instr == rrr_pkg::OPC_RTS || status_word[rrr_pkg::SW_MD_BIT])
      |=> (irq_hold && !pc_wr.we) [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("hold or early branch wrong");
  property p_rc_reg;
    t_reg |=> s_quiet_sw ##1 (sw_wr.we
      && ((sw_wr.data >> 16) & rrr_pkg::RC_SRC_MASK) == ($past(gr_rdata, 3) & rrr_pkg::RC_SRC_MASK)
      && sw_wr.data[3:2] == $past(repeat_flags)
      && (sw_wr.data & rrr_pkg::SW_CLR_MASK) == ($past(status_word) & rrr_pkg::SW_CLR_MASK));
  endproperty
  a_rc_reg: assert property (p_rc_reg) else $error("register count set wrong");
  property p_rc_imm;
    t_imm |=> s_quiet_sw ##1 (sw_wr.we && sw_wr.data[27:16] == {4'h0, $past(instr[7:0], 3)});
  endproperty
  a_rc_imm: assert property (p_rc_imm) else $error("immediate count set wrong");
endmodule

bind rrr_exec rrr_exec_props u_props (.clk, .srst, .instr_valid, .instr, .instr_in_slot, .ready,
  .gr_rdata, .status_word, .saved_status_word, .repeat_flags, .gr_wr, .sw_wr, .pc_wr, .exc, .irq_hold);

// ---- sim/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, srst = 1, instr_valid = 0, instr_is_branch = 0, instr_in_slot = 0;
  logic ready, irq_hold, irq, reg_wr = 0, reg_rd = 0;
  logic [15:0] instr = 16'h0009;
  logic [31:0] gr_rdata = 0, status_word = 0, saved_status_word = 0, saved_program_counter = 0;
  logic [31:0] procedure_return_reg = 0, reg_wdata = 0, reg_rdata, sw_q, pc_q, d;
  logic [1:0]  repeat_flags = 0, cause_q;
  logic [3:0]  reg_addr = 0;
  rrr_pkg::rrr_gr_wr_type   gr_wr, g_q;
  rrr_pkg::rrr_word_wr_type sw_wr, pc_wr;
  rrr_pkg::rrr_exc_type     exc;
  int errors = 0, tests_run = 0, pc_n = 0, exc_n = 0, p0;
  always #25 clk = ~clk;
  rrr_exec dut (.clk, .srst, .instr_valid, .instr, .instr_is_branch, .instr_in_slot, .ready, .gr_rdata,
    .status_word, .saved_status_word, .saved_program_counter, .procedure_return_reg, .repeat_flags,
    .gr_wr, .sw_wr, .pc_wr, .exc, .irq_hold, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  ////////////////////////////////////////////////////////////////////
  // Capture of output pulses
  always @(posedge clk) begin
    if (gr_wr.we === 1'b1) g_q <= gr_wr;
    if (sw_wr.we === 1'b1) sw_q <= sw_wr.data;
    if (pc_wr.we === 1'b1) begin pc_q <= pc_wr.data; pc_n <= pc_n + 1; end
    if (exc.valid === 1'b1) begin cause_q <= exc.cause; exc_n <= exc_n + 1; end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin errors++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  // Offer one instruction until taken
  task automatic issue(input logic [15:0] op, input logic br, input logic sl);
    int n;
    n = 0;
    @(posedge clk);
    instr <= op; instr_is_branch <= br; instr_in_slot <= sl; instr_valid <= 1'b1;
    @(negedge clk);
    while (ready !== 1'b1 && n < 20) begin @(negedge clk); n++; end
    @(posedge clk);
    instr_valid <= 1'b0; instr_is_branch <= 1'b0; instr_in_slot <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk); reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0;
    @(negedge clk); v = reg_rdata;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_rotate;
    @(posedge clk); gr_rdata <= 32'h80000001; issue(16'h4304, 0, 0); idle(1);
    chk(g_q.data, 32'h00000003); chk({31'h0, g_q.t_val}, 1); chk({28'h0, g_q.idx}, 3);
    @(posedge clk); gr_rdata <= 32'h00000002; issue(16'h4a05, 0, 0); idle(1);
    chk(g_q.data, 32'h00000001); chk({31'h0, g_q.t_val}, 0); chk({28'h0, g_q.idx}, 10);
  endtask
  task automatic t_rte;
    @(posedge clk); status_word <= 32'h40000000; saved_status_word <= 32'h700000f0;
    saved_program_counter <= 32'h00008000; p0 = pc_n;
    issue(rrr_pkg::OPC_RTE, 0, 0); @(negedge clk);
    chk({31'h0, irq_hold}, 1);
    idle(5); chk(sw_q, 32'h700000f0); chk(pc_n - p0, 0);
    issue(16'h0009, 0, 0); idle(3);
    chk(pc_q, 32'h00008000); chk(pc_n - p0, 1);
    @(posedge clk); status_word <= 32'h0; p0 = exc_n;
    issue(rrr_pkg::OPC_RTE, 0, 0); idle(2);
    chk({30'h0, cause_q}, 1); chk(exc_n - p0, 1);
  endtask
  task automatic t_rts;
    @(posedge clk); procedure_return_reg <= 32'h00004444;
    issue(rrr_pkg::OPC_RTS, 0, 0);
    procedure_return_reg <= 32'h00005555;
    issue(16'h0009, 0, 0); idle(3);
    chk(pc_q, 32'h00004444);
  endtask
  task automatic t_bad_slot;
    p0 = pc_n;
    issue(rrr_pkg::OPC_RTS, 0, 0); issue(16'h0009, 1, 0); idle(2);
    chk({30'h0, cause_q}, 2); chk(pc_n - p0, 0);
    @(posedge clk); status_word <= 32'h40000000; p0 = exc_n;
    issue(rrr_pkg::OPC_RTE, 0, 1); idle(2);
    chk({30'h0, cause_q}, 2); chk(exc_n - p0, 1);
  endtask
  task automatic t_repeat;
    @(posedge clk); status_word <= 32'hffffffff; gr_rdata <= 32'hfffff123; repeat_flags <= 2'h2;
    issue(16'h4514, 0, 0); idle(4);
    chk(sw_q, 32'hf123fffb);
    @(posedge clk); status_word <= 32'h0; repeat_flags <= 2'h1;
    issue(16'h82a5, 0, 0); idle(4);
    chk(sw_q, 32'h00a50004);
  endtask
  task automatic t_regs_end;
    rd(rrr_pkg::REG_STAT, d); chk(d, 32'h0000000f);
    chk({31'h0, irq}, 0);
    wr(rrr_pkg::REG_MASK, 32'h2); idle(3); chk({31'h0, irq}, 1);
    wr(rrr_pkg::REG_STAT, 32'h2); idle(3); chk({31'h0, irq}, 0);
    rd(rrr_pkg::REG_STAT, d); chk(d, 32'h0000000d);
    rd(rrr_pkg::REG_MASK, d); chk(d, 32'h00000002);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #100us;
    errors++;
    results();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(rrr_pkg::REG_CTRL, d); chk(d, 32'h00000001);
    rd(rrr_pkg::REG_MASK, d); chk(d, 32'h00000000);
    rd(4'h1, d); chk(d, 32'h00000000);
    rd(rrr_pkg::REG_INFO, d); chk(d, 32'h00000011);
    t_rotate();
    t_rte();
    t_rts();
    t_bad_slot();
    t_repeat();
    t_regs_end();
    results();
  end
endmodule

// ---- verilog/rrr_exec.sv ----
// The implementer's own choices: strobed register access and the placing of the registers.
module rrr_exec (
  input  wire logic                     clk,
  input  wire logic                     srst,
  // Instruction issue
  input  wire logic                     instr_valid,
  input  wire logic [15:0]              instr,
  input  wire logic                     instr_is_branch,
  input  wire logic                     instr_in_slot,
  output logic                          ready,
  // Core state read
  input  wire logic [31:0]              gr_rdata,
  input  wire logic [31:0]              status_word,
  input  wire logic [31:0]              saved_status_word,
  input  wire logic [31:0]              saved_program_counter,
  input  wire logic [31:0]              procedure_return_reg,
  input  wire logic [1:0]               repeat_flags,
  // Core state write
  output rrr_pkg::rrr_gr_wr_type        gr_wr,
  output rrr_pkg::rrr_word_wr_type      sw_wr,
  output rrr_pkg::rrr_word_wr_type      pc_wr,
  output rrr_pkg::rrr_exc_type          exc,
  output logic                          irq_hold,
  // Register port
  input  wire logic [3:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [31:0]                   reg_rdata,
  output logic                          irq
);

  ////////////////////////////////////////////////////////////////////
  // Opcode compare under a mask
  function automatic logic opc_hit(input logic [15:0] code,
                                   input logic [15:0] pat,
                                   input logic [15:0] msk);
    opc_hit = ((code & msk) == pat);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State
  rrr_pkg::rrr_state_type   state_q;           // Sequencer state
  logic [2:0]               cnt_q;             // Remaining cycles
  logic                     ready_q;           // Ready to accept an issue
  logic                     op_rte_q;          // Pending exception return
  logic                     op_set_q;          // Pending repeat set
  logic [31:0]              target_q;          // Branch destination
  logic [31:0]              val_q;             // Saved word or count
  rrr_pkg::rrr_gr_wr_type   gr_wr_q;           // Register write out
  rrr_pkg::rrr_word_wr_type sw_wr_q;           // Status write out
  rrr_pkg::rrr_word_wr_type pc_wr_q;           // Counter write out
  rrr_pkg::rrr_exc_type     exc_q;             // Exception out
  logic                     hold_q;            // Interrupt hold
  logic [1:0]               last_cause_q;      // Last raised cause
  logic [31:0]              ctrl_q;            // Control register
  logic [3:0]               stat_q;            // Sticky events
  logic [3:0]               mask_q;            // Event enables
  logic [31:0]              rdata_q;           // Read data
  logic                     irq_q;             // Interrupt line

  ////////////////////////////////////////////////////////////////////
  // Decode
  wire en        = ctrl_q[0];                                // Block enable
  wire take      = instr_valid & ready_q & en;               // Issue taken
  wire dec_rotate_left_op  = opc_hit(instr, rrr_pkg::OPC_ROTATE_LEFT_OP, rrr_pkg::MSK_REG);
  wire dec_rotate_right_op  = opc_hit(instr, rrr_pkg::OPC_ROTATE_RIGHT_OP, rrr_pkg::MSK_REG);
  wire dec_rte   = opc_hit(instr, rrr_pkg::OPC_RTE, rrr_pkg::MSK_FIXED);
  wire dec_rts   = opc_hit(instr, rrr_pkg::OPC_RTS, rrr_pkg::MSK_FIXED);
  wire dec_setr  = opc_hit(instr, rrr_pkg::OPC_SET_REG, rrr_pkg::MSK_REG);
  wire dec_seti  = opc_hit(instr, rrr_pkg::OPC_SET_IMM, rrr_pkg::MSK_IMM);
  wire is_ret    = dec_rte | dec_rts;
  wire in_slot   = (state_q == rrr_pkg::ST_SLOT);
  wire slot_bad  = in_slot & (instr_is_branch | is_ret);
  wire ret_bad   = is_ret & instr_in_slot;
  wire user_rte  = dec_rte & ~status_word[rrr_pkg::SW_MD_BIT];
  wire ok        = take & ~slot_bad;                          // Clean issue
  wire go_rot    = ok & (dec_rotate_left_op | dec_rotate_right_op);
  wire go_ret    = ok & is_ret & ~ret_bad & ~user_rte;
  wire go_set    = ok & (dec_setr | dec_seti);
  wire slot_ok   = ok & in_slot;
  wire done      = (state_q == rrr_pkg::ST_WAIT) & (cnt_q == 3'h1);

  // Exception cause, slot fault first
  wire       exc_hit   = take & (slot_bad | ret_bad | user_rte);
  wire [1:0] exc_cause = (slot_bad | ret_bad) ? rrr_pkg::CAUSE_ILL_SLOT
                                              : rrr_pkg::CAUSE_ILL_INSTR;

  // Rotate result and test flag
  wire [31:0] rot_res = dec_rotate_left_op ? {gr_rdata[30:0], gr_rdata[31]}
                                 : {gr_rdata[0], gr_rdata[31:1]};
  wire        rot_t   = dec_rotate_left_op ? gr_rdata[31] : gr_rdata[0];

  // Repeat count source
  wire [31:0] cnt_src = dec_setr ? (gr_rdata & rrr_pkg::RC_SRC_MASK)
                                 : ({24'h0, instr[7:0]} & rrr_pkg::RC_IMM_MASK);

  // Destination and cycle count latched at issue
  wire [31:0] ret_tgt = dec_rte ? saved_program_counter
                                : procedure_return_reg;
  wire [2:0]  op_cyc  = dec_rte ? rrr_pkg::CYC_RTE
                      : dec_rts ? rrr_pkg::CYC_RTS : rrr_pkg::CYC_SET;

  // Merged status word for repeat set
  wire [31:0] sw_rc   = (status_word & rrr_pkg::SW_CLR_MASK)
                      | (val_q << rrr_pkg::RC_LSB)
                      | ({30'h0, repeat_flags} << rrr_pkg::RF_LSB);

  // Next state
  rrr_pkg::rrr_state_type state_d;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      rrr_pkg::ST_IDLE: begin
        if (go_ret | go_set) begin
          state_d = rrr_pkg::ST_WAIT;
        end
      end
      rrr_pkg::ST_WAIT: begin
        if (done) begin
          state_d = op_set_q ? rrr_pkg::ST_IDLE : rrr_pkg::ST_SLOT;
        end
      end
      rrr_pkg::ST_SLOT: begin
        if (take) begin
          // Slot instruction may start a repeat set
          state_d = go_set ? rrr_pkg::ST_WAIT : rrr_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = rrr_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer and cycle counter
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= rrr_pkg::ST_IDLE;
      cnt_q   <= 3'h0;
    end else begin
      state_q <= state_d;
      if (go_ret | go_set) begin
        cnt_q <= op_cyc - 3'h1;
      end else if (cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Issue readiness; slot waits one cycle past the restore
  always_ff @(posedge clk) begin
    if (srst) begin
      ready_q <= 1'b1;
    end else if (go_ret | go_set) begin
      ready_q <= 1'b0;
    end else if (done & op_set_q) begin
      ready_q <= 1'b1;
    end else if (in_slot & ~ready_q) begin
      ready_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Operands captured when the instruction issues
  always_ff @(posedge clk) begin
    if (srst) begin
      op_rte_q <= 1'b0;
      op_set_q <= 1'b0;
      target_q <= 32'h0;
      val_q    <= 32'h0;
    end else if (go_ret) begin
      op_rte_q <= dec_rte;
      op_set_q <= 1'b0;
      target_q <= ret_tgt;
      val_q    <= saved_status_word;
    end else if (go_set) begin
      op_rte_q <= 1'b0;
      op_set_q <= 1'b1;
      val_q    <= cnt_src;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // One-cycle rotate writes
  always_ff @(posedge clk) begin
    if (srst) begin
      gr_wr_q <= '0;
    end else begin
      gr_wr_q.we    <= go_rot;
      gr_wr_q.idx   <= instr[11:8];
      gr_wr_q.data  <= rot_res;
      gr_wr_q.t_we  <= go_rot;
      gr_wr_q.t_val <= rot_t;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status word writes at completion
  always_ff @(posedge clk) begin
    if (srst) begin
      sw_wr_q <= '0;
    end else begin
      sw_wr_q.we   <= done & (op_rte_q | op_set_q);
      sw_wr_q.data <= op_set_q ? sw_rc : val_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Branch after a clean slot instruction
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_wr_q <= '0;
    end else begin
      pc_wr_q.we   <= slot_ok;
      pc_wr_q.data <= target_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Exception pulse and interrupt hold
  always_ff @(posedge clk) begin
    if (srst) begin
      exc_q        <= '0;
      last_cause_q <= rrr_pkg::CAUSE_NONE;
      hold_q       <= 1'b0;
    end else begin
      exc_q.valid <= exc_hit;
      exc_q.cause <= exc_hit ? exc_cause : rrr_pkg::CAUSE_NONE;
      if (exc_hit) begin
        last_cause_q <= exc_cause;
      end
      if (go_ret) begin
        hold_q <= 1'b1;
      end else if (in_slot & take) begin
        hold_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register port decode
  wire        wr_ctrl = reg_wr & (reg_addr == rrr_pkg::REG_CTRL);
  wire        wr_stat = reg_wr & (reg_addr == rrr_pkg::REG_STAT);
  wire        wr_mask = reg_wr & (reg_addr == rrr_pkg::REG_MASK);
  wire [3:0]  ev      = {sw_wr_q.we & ~op_rte_q & (state_q == rrr_pkg::ST_IDLE),
                         pc_wr_q.we,
                         exc_q.valid & (exc_q.cause == rrr_pkg::CAUSE_ILL_SLOT),
                         exc_q.valid & (exc_q.cause == rrr_pkg::CAUSE_ILL_INSTR)};
  wire [3:0]  clr     = wr_stat ? reg_wdata[3:0] : 4'h0;
  wire [31:0] info    = {24'h0, last_cause_q, hold_q, ready_q, 1'b0, state_q};
  wire [31:0] rd_mux  = (reg_addr == rrr_pkg::REG_CTRL) ? ctrl_q
                      : (reg_addr == rrr_pkg::REG_STAT) ? {28'h0, stat_q}
                      : (reg_addr == rrr_pkg::REG_MASK) ? {28'h0, mask_q}
                      : (reg_addr == rrr_pkg::REG_INFO) ? info
                      : 32'h0;

  ////////////////////////////////////////////////////////////////////
  // Control and mask registers
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= rrr_pkg::CTRL_RST;
      mask_q <= rrr_pkg::MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {31'h0, reg_wdata[0]};
      end
      if (wr_mask) begin
        mask_q <= reg_wdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sticky events, set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      stat_q <= 4'h0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~clr) | ev;
      irq_q  <= |(((stat_q & ~clr) | ev) & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // Outputs straight from flops
  assign ready     = ready_q;
  assign gr_wr     = gr_wr_q;
  assign sw_wr     = sw_wr_q;
  assign pc_wr     = pc_wr_q;
  assign exc       = exc_q;
  assign irq_hold  = hold_q;
  assign reg_rdata = rdata_q;
  assign irq       = irq_q;

endmodule

// ---- verilog/rrr_pkg.sv ----
// Function
// - Rotate left: top bit to test flag, bit zero
// - Rotate right: bit zero to test flag, top
// - Exception return loads saved counter and word
// - User-mode exception return raises illegal instruction
// - Returns branch after one delay-slot instruction
// - No interrupt between return and slot
// - Branch in return slot is illegal slot
// - Return inside another slot is illegal slot
// - Slot runs under restored status word
// - Destination taken before slot executes
// - Subroutine return loads counter from return register
// - Register form writes low twelve bits, three cycles
// - Immediate form zero-extends eight bits, three cycles
// - Repeat flags updated from repeat control state
// - Count at bit sixteen, fixed clear mask
package rrr_pkg;

  ////////////////////////////////////////////////////////////////////
  // Opcode patterns and their compare masks
  localparam logic [15:0] OPC_ROTATE_LEFT_OP    = 16'h4004;
  localparam logic [15:0] OPC_ROTATE_RIGHT_OP    = 16'h4005;
  localparam logic [15:0] OPC_RTE     = 16'h002b;
  localparam logic [15:0] OPC_RTS     = 16'h000b;
  localparam logic [15:0] OPC_SET_REG = 16'h4014;
  localparam logic [15:0] OPC_SET_IMM = 16'h8200;
  localparam logic [15:0] MSK_REG     = 16'hf0ff;  // Register field free
  localparam logic [15:0] MSK_FIXED   = 16'hffff;  // Fully fixed code
  localparam logic [15:0] MSK_IMM     = 16'hff00;  // Immediate field free

  ////////////////////////////////////////////////////////////////////
  // Execution cycle counts
  localparam logic [2:0] CYC_RTE = 3'h4;
  localparam logic [2:0] CYC_RTS = 3'h2;
  localparam logic [2:0] CYC_SET = 3'h3;

  ////////////////////////////////////////////////////////////////////
  // Status word layout
  localparam logic [31:0] RC_SRC_MASK  = 32'h00000fff;  // Count bits of source
  localparam logic [31:0] RC_IMM_MASK  = 32'h000000ff;  // Immediate count bits
  localparam logic [31:0] SW_CLR_MASK  = 32'hf000fff3;  // Clears count and flags
  localparam int          RC_LSB       = 16;            // Repeat counter base
  localparam int          RF_LSB       = 2;             // Repeat flag low bit
  localparam int          SW_MD_BIT    = 30;            // Privileged mode bit

  ////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_STAT  = 4'h4;
  localparam logic [3:0] REG_MASK  = 4'h8;
  localparam logic [3:0] REG_INFO  = 4'hc;
  localparam logic [31:0] CTRL_RST = 32'h00000001;  // Enabled out of reset
  localparam logic [3:0]  MASK_RST = 4'h0;          // All events masked

  ////////////////////////////////////////////////////////////////////
  // Event bits in status and mask
  localparam int EV_ILL_INSTR = 0;
  localparam int EV_ILL_SLOT  = 1;
  localparam int EV_BRANCH    = 2;
  localparam int EV_REPEAT    = 3;
  localparam int EV_NUM       = 4;

  ////////////////////////////////////////////////////////////////////
  // Exception causes
  localparam logic [1:0] CAUSE_NONE      = 2'h0;
  localparam logic [1:0] CAUSE_ILL_INSTR = 2'h1;
  localparam logic [1:0] CAUSE_ILL_SLOT  = 2'h2;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SLOT = 3'b100
  } rrr_state_type;

  // General register write with test flag
  typedef struct packed {
    logic        we;
    logic [3:0]  idx;
    logic [31:0] data;
    logic        t_we;
    logic        t_val;
  } rrr_gr_wr_type;

  // Word write for status word or program counter
  typedef struct packed {
    logic        we;
    logic [31:0] data;
  } rrr_word_wr_type;

  // Exception request toward exception logic
  typedef struct packed {
    logic       valid;
    logic [1:0] cause;
  } rrr_exc_type;

endpackage
